// ==== verilog/tape_device.sv ====
// What this block does
// - Direction true runs motor forward
// - Direction false runs motor backward
// - Write-only controller holds direction true; here CTRL_FWD only resets true and a REG_CTRL write can clear it
// - Parity even when polarity true, else odd
// - Ready once loaded with head current
// - Controller writes only ready and no gap
// - Gap-active while gapping logic drives tape
// - Gap-active extended by settling delay
// - Controller never writes during gap-active
// - Tape_end_marker_sensed output follows marker sensor
// - Write error raised within echo deadline
// - Write error holds until next strobe
// - Oscillator pulses last at least 10 us
// - Oscillator runs on slew, loading or gapping
// - Oscillator ramps up to 1000 per second
// - Controller gates oscillator pulses externally
// - Start marker output starts tape start gap
// - Strobe latches data, steps one character
// - Slew starts accelerating oscillator
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "tape_port_cfg.svh"
module tape_device
  import tape_pkg::*;
#(
  parameter logic [19:0] OSC_NOM_CYC   = 20'(`OSC_NOM_CYC),
  parameter logic [19:0] OSC_START_CYC = 20'(`OSC_START_CYC),
  parameter logic [19:0] SETTLE_CYC    = 20'(`SETTLE_CYC)
)
(
  input  wire logic  pclk,
  input  wire logic  presetn,
  tape_link_if.dev   link,
  input  wire logic  load_req_pin,
  input  wire logic  load_point_pin,
  input  wire logic  end_marker_pin,
  input  wire logic  head_current_pin,
  input  wire logic  echo_fail_pin,
  output logic       motor_step,
  output logic       motor_fwd,
  output logic [6:0] head_data,
  output logic       head_write
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [4:0] pin_s1_r;
  logic [4:0] pin_s2_r;
  logic [4:0] pin_s3_r;
  logic [4:0] pin_r;
  logic       load_req;
  logic       load_point;
  logic       end_marker;
  logic       head_ok;
  logic       echo_fail;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_r <= 5'h00;
      pin_s2_r <= 5'h00;
      pin_s3_r <= 5'h00;
      pin_r    <= 5'h00;
    end
    else
    begin
      pin_s1_r <= {load_req_pin, load_point_pin, end_marker_pin, head_current_pin,
                   echo_fail_pin};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_r    <= (pin_s3_r & ~(pin_s2_r ^ pin_s3_r)) | (pin_r & (pin_s2_r ^ pin_s3_r));
    end
  end

  assign {load_req, load_point, end_marker, head_ok, echo_fail} = pin_r;

  // ----------------------------------------
  // Link edge detect
  // ----------------------------------------
  logic strobe_d_r;
  logic eor_d_r;
  logic eof_d_r;
  logic strobe_rise;
  logic eor_rise;
  logic eof_rise;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strobe_d_r <= 1'b0;
      eor_d_r    <= 1'b0;
      eof_d_r    <= 1'b0;
    end
    else
    begin
      strobe_d_r <= link.write_strobe;
      eor_d_r    <= link.eor_cmd;
      eof_d_r    <= link.eof_cmd;
    end
  end

  assign strobe_rise = link.write_strobe & ~strobe_d_r;
  assign eor_rise    = link.eor_cmd & ~eor_d_r;
  assign eof_rise    = link.eof_cmd & ~eof_d_r;

  // ----------------------------------------
  // Step oscillator
  // ----------------------------------------
  localparam logic [19:0] OSC_PW_CYC = 20'(`OSC_PW_CYC);
  localparam logic [19:0] RAMP_DEC   = 20'((OSC_START_CYC - OSC_NOM_CYC) / `RAMP_STEPS);

  dev_state_t  state_r;
  logic        osc_run;
  logic        osc_tick;
  logic [19:0] phase_r;
  logic [19:0] per_r;
  logic        osc_out_r;

  assign osc_run  = link.slew || state_r == ST_LOADING || state_r == ST_GAP;
  assign osc_tick = osc_run && phase_r == 20'h00000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_r   <= 20'h00000;
      per_r     <= 20'h00000;
      osc_out_r <= 1'b0;
    end
    else if (!osc_run)
    begin
      phase_r   <= osc_out_r ? phase_r + 20'h00001 : 20'h00000;
      per_r     <= OSC_START_CYC;
      osc_out_r <= osc_out_r && phase_r < OSC_PW_CYC;
    end
    else
    begin
      osc_out_r <= phase_r < OSC_PW_CYC;
      if (phase_r >= per_r - 20'h00001)
      begin
        phase_r <= 20'h00000;
        if (per_r - RAMP_DEC > OSC_NOM_CYC)
          per_r <= per_r - RAMP_DEC;
        else
          per_r <= OSC_NOM_CYC;
      end
      else
        phase_r <= phase_r + 20'h00001;
    end
  end

  assign link.osc_out = osc_out_r;

  // ----------------------------------------
  // Tape sequence
  // ----------------------------------------
  logic [9:0]  steps_r;
  logic [19:0] settle_r;
  logic        loaded_r;
  logic        take;

  assign take = state_r == ST_READY && strobe_rise;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r  <= ST_UNLOADED;
      steps_r  <= 10'h000;
      settle_r <= 20'h00000;
      loaded_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_UNLOADED:
          if (load_req)
            state_r <= ST_LOADING;
        ST_LOADING:
          if (load_point)
          begin
            state_r <= ST_GAP;
            steps_r <= 10'(`GAP_START_STEPS);
          end
        ST_GAP:
          if (osc_tick)
          begin
            if (steps_r <= 10'h001)
            begin
              state_r  <= ST_SETTLE;
              settle_r <= SETTLE_CYC;
            end
            else
              steps_r <= steps_r - 10'h001;
          end
        ST_SETTLE:
          if (settle_r <= 20'h00001)
          begin
            state_r  <= ST_READY;
            loaded_r <= 1'b1;
          end
          else
            settle_r <= settle_r - 20'h00001;
        ST_READY:
          if (eof_rise)
          begin
            state_r <= ST_GAP;
            steps_r <= 10'(`GAP_FILE_STEPS);
          end
          else if (eor_rise)
          begin
            state_r <= ST_GAP;
            steps_r <= 10'(`GAP_REC_STEPS);
          end
      endcase
    end
  end

  assign link.ready      = loaded_r & head_ok;
  assign link.gap_active = state_r == ST_GAP || state_r == ST_SETTLE;
  assign link.tape_end_marker_sensed = end_marker;
  assign link.start_marker = load_point;

  // ----------------------------------------
  // Character write and motor
  // ----------------------------------------
  logic [6:0] head_data_r;
  logic       head_write_r;
  logic       step_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      head_data_r  <= 7'h00;
      head_write_r <= 1'b0;
      step_r       <= 1'b0;
    end
    else
    begin
      head_write_r <= take;
      step_r       <= take | osc_tick;
      if (take)
        head_data_r <= {^link.char_data ^ ~link.parity_even, link.char_data};
    end
  end

  assign head_data  = head_data_r;
  assign head_write = head_write_r;
  assign motor_step = step_r;
  assign motor_fwd  = link.fwd_sel;

  // ----------------------------------------
  // Echo check
  // ----------------------------------------
  localparam logic [12:0] ECHO_CYC = 13'(`ECHO_CYC);

  logic [12:0] echo_win_r;
  logic        werr_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      echo_win_r <= 13'h0000;
      werr_r     <= 1'b0;
    end
    else if (strobe_rise)
    begin
      werr_r     <= 1'b0;
      echo_win_r <= take ? ECHO_CYC : 13'h0000;
    end
    else if (echo_win_r != 13'h0000)
    begin
      echo_win_r <= echo_win_r - 13'h0001;
      if (echo_fail)
        werr_r <= 1'b1;
    end
  end

  assign link.write_error = werr_r;

endmodule
`default_nettype wire

// ==== verilog/tape_port_cfg.svh ====
`ifndef TAPE_PORT_CFG_SVH
`define TAPE_PORT_CFG_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ         40
`define OSC_PW_US       10
`define OSC_PW_CYC      (`OSC_PW_US * `CLK_MHZ)
`define OSC_NOM_US      1000
`define OSC_NOM_CYC     (`OSC_NOM_US * `CLK_MHZ)
`define OSC_START_US    4000
`define OSC_START_CYC   (`OSC_START_US * `CLK_MHZ)
`define RAMP_STEPS      16
`define SETTLE_US       10000
`define SETTLE_CYC      (`SETTLE_US * `CLK_MHZ)
`define ECHO_US         100
`define ECHO_CYC        (`ECHO_US * `CLK_MHZ)
`define STROBE_US       20
`define STROBE_CYC      (`STROBE_US * `CLK_MHZ)
// ----------------------------------------
// Gap lengths in motor steps
// ----------------------------------------
`define GAP_REC_STEPS   150
`define GAP_FILE_STEPS  700
`define GAP_START_STEPS 100
// ----------------------------------------
// Controller registers
// ----------------------------------------
`define REG_CTRL        12'h000
`define REG_DATA        12'h004
`define REG_CMD         12'h008
`define REG_STAT        12'h00c
`define REG_IRQ_ST      12'h010
`define REG_IRQ_MSK     12'h014
`define CTRL_FWD        0
`define CTRL_PAR_EVEN   1
`define CTRL_SLEW       2
`define CTRL_RST        3'h3
`define CMD_EOR         0
`define CMD_EOF         1
`define IRQ_WERR        0
`define IRQ_GAP_DONE    1
`define IRQ_TAPE_END    2
`define IRQ_REFUSED     3
`endif

// ==== verilog/tape_pkg.sv ====
`default_nettype none
package tape_pkg;
  typedef enum logic [4:0] {
    ST_UNLOADED = 5'b00001,
    ST_LOADING  = 5'b00010,
    ST_GAP      = 5'b00100,
    ST_SETTLE   = 5'b01000,
    ST_READY    = 5'b10000
  } dev_state_t;
  typedef logic [5:0] char_t;
endpackage
`default_nettype wire

// ==== verilog/tape_link_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface tape_link_if;
  import tape_pkg::*;
  logic  fwd_sel;
  logic  parity_even;
  logic  slew;
  logic  write_strobe;
  char_t char_data;
  logic  eor_cmd;
  logic  eof_cmd;
  logic  ready;
  logic  gap_active;
  logic  tape_end_marker_sensed;
  logic  start_marker;
  logic  write_error;
  logic  osc_out;
  modport dev (input fwd_sel, parity_even, slew, write_strobe, char_data, eor_cmd, eof_cmd,
               output ready, gap_active, tape_end_marker_sensed, start_marker, write_error,
               osc_out);
  modport ctl (output fwd_sel, parity_even, slew, write_strobe, char_data, eor_cmd, eof_cmd,
               input ready, gap_active, tape_end_marker_sensed, start_marker, write_error,
               osc_out);
endinterface
`default_nettype wire

// ==== verilog/tape_controller.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "tape_port_cfg.svh"
module tape_controller
  import tape_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic             data_clk,
  tape_link_if.ctl         link
);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic wr;
  logic rd;
  logic mapped;

  assign wr     = psel & penable & pwrite;
  assign rd     = psel & penable & ~pwrite;
  assign mapped = paddr == `REG_CTRL || paddr == `REG_DATA || paddr == `REG_CMD ||
                  paddr == `REG_STAT || paddr == `REG_IRQ_ST || paddr == `REG_IRQ_MSK;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ----------------------------------------
  // Commands to the recorder
  // ----------------------------------------
  logic [2:0]  ctrl_r;
  char_t       char_r;
  logic [9:0]  busy_r;
  logic        strobe_r;
  logic        eor_r;
  logic        eof_r;
  logic        can_write;
  logic        refused;
  logic        wr_data;
  logic        wr_cmd;

  assign can_write = link.ready & ~link.gap_active & busy_r == 10'h000;
  assign wr_data   = wr && paddr == `REG_DATA;
  assign wr_cmd    = wr && paddr == `REG_CMD && pwdata[1:0] != 2'h0;
  assign refused   = (wr_data | wr_cmd) & ~can_write;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= `CTRL_RST;
    else if (wr && paddr == `REG_CTRL)
      ctrl_r <= pwdata[2:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      char_r   <= 6'h00;
      busy_r   <= 10'h000;
      strobe_r <= 1'b0;
      eor_r    <= 1'b0;
      eof_r    <= 1'b0;
    end
    else if (can_write && (wr_data || wr_cmd))
    begin
      busy_r   <= 10'(`STROBE_CYC);
      strobe_r <= wr_data;
      eor_r    <= wr_cmd & pwdata[`CMD_EOR];
      eof_r    <= wr_cmd & pwdata[`CMD_EOF];
      if (wr_data)
        char_r <= pwdata[5:0];
    end
    else if (busy_r != 10'h000)
    begin
      busy_r <= busy_r - 10'h001;
      if (busy_r == 10'h001)
      begin
        strobe_r <= 1'b0;
        eor_r    <= 1'b0;
        eof_r    <= 1'b0;
      end
    end
  end

  assign link.fwd_sel      = ctrl_r[`CTRL_FWD];
  assign link.parity_even  = ctrl_r[`CTRL_PAR_EVEN];
  assign link.slew         = ctrl_r[`CTRL_SLEW];
  assign link.char_data    = char_r;
  assign link.write_strobe = strobe_r;
  assign link.eor_cmd      = eor_r;
  assign link.eof_cmd      = eof_r;

  // ----------------------------------------
  // Oscillator gating and events
  // ----------------------------------------
  logic       osc_d_r;
  logic       werr_d_r;
  logic       gap_d_r;
  logic       end_d_r;
  logic [3:0] ev;
  logic [3:0] irq_st_r;
  logic [3:0] irq_msk_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_d_r  <= 1'b0;
      werr_d_r <= 1'b0;
      gap_d_r  <= 1'b0;
      end_d_r  <= 1'b0;
    end
    else
    begin
      osc_d_r  <= link.osc_out;
      werr_d_r <= link.write_error;
      gap_d_r  <= link.gap_active;
      end_d_r  <= link.tape_end_marker_sensed;
    end
  end

  assign data_clk = link.osc_out & ~osc_d_r & link.ready & ~link.gap_active;

  assign ev[`IRQ_WERR]     = link.write_error & ~werr_d_r;
  assign ev[`IRQ_GAP_DONE] = gap_d_r & ~link.gap_active;
  assign ev[`IRQ_TAPE_END] = link.tape_end_marker_sensed & ~end_d_r;
  assign ev[`IRQ_REFUSED]  = refused;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_st_r  <= 4'h0;
      irq_msk_r <= 4'h0;
    end
    else
    begin
      if (wr && paddr == `REG_IRQ_ST)
        irq_st_r <= (irq_st_r & ~pwdata[3:0]) | ev;
      else
        irq_st_r <= irq_st_r | ev;
      if (wr && paddr == `REG_IRQ_MSK)
        irq_msk_r <= pwdata[3:0];
    end
  end

  assign irq = |(irq_st_r & irq_msk_r);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb
  begin
    prdata = 32'h00000000;
    if (rd)
    begin
      unique case (paddr)
        `REG_CTRL:    prdata = {29'h0, ctrl_r};
        `REG_DATA:    prdata = {26'h0, char_r};
        `REG_STAT:    prdata = {26'h0, busy_r != 10'h000, link.write_error,
                                link.start_marker, link.tape_end_marker_sensed,
                                link.gap_active, link.ready};
        `REG_IRQ_ST:  prdata = {28'h0, irq_st_r};
        `REG_IRQ_MSK: prdata = {28'h0, irq_msk_r};
        default:      prdata = 32'h00000000;
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== dv/tape_link_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module tape_link_asserts
#(
  parameter int SETTLE_CYC = 200
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slew,
  input wire logic write_strobe,
  input wire logic eor_cmd,
  input wire logic eof_cmd,
  input wire logic ready,
  input wire logic gap_active,
  input wire logic write_error,
  input wire logic osc_out
);
  localparam int OSC_WAIT = 1000;
  logic        osc_d_r;
  logic        stb_d_r;
  logic [19:0] osc_age_r;
  logic [19:0] hi_len_r;
  logic [19:0] stb_age_r;
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      osc_d_r <= 1'b0;
      stb_d_r <= 1'b0;
    end
    else
    begin
      osc_d_r <= osc_out;
      stb_d_r <= write_strobe;
    end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      osc_age_r <= 20'h0;
    else if (osc_out && !osc_d_r)
      osc_age_r <= 20'h0;
    else if (osc_age_r != 20'hfffff)
      osc_age_r <= osc_age_r + 20'h1;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      hi_len_r <= 20'h0;
    else if (!osc_out)
      hi_len_r <= 20'h0;
    else
      hi_len_r <= hi_len_r + 20'h1;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      stb_age_r <= 20'h0;
    else if (write_strobe && !stb_d_r)
      stb_age_r <= 20'h0;
    else if (stb_age_r != 20'hfffff)
      stb_age_r <= stb_age_r + 20'h1;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence cmd_taken_s;
    ready && !gap_active && $rose(eor_cmd || eof_cmd);
  endsequence
  sequence osc_idle_s;
    ready && !gap_active && !slew && !$past(slew) && !$past(slew, 2) && !eor_cmd && !eof_cmd;
  endsequence
  AST_GAP_ON_CMD: assert property (cmd_taken_s |-> ##[1:2] gap_active)
    else $error("gap not raised after command");
  AST_GAP_SETTLE: assert property ($fell(gap_active) && !slew |-> osc_age_r >= SETTLE_CYC - 1)
    else $error("gap ended without settle delay");
  AST_OSC_WIDTH: assert property ($fell(osc_out) |-> hi_len_r >= 20'h190)
    else $error("oscillator pulse too short");
  AST_OSC_ON_SLEW: assert property ($rose(slew) && ready |-> ##[1:OSC_WAIT] $rose(osc_out))
    else $error("no oscillator pulse after slew");
  AST_OSC_QUIET: assert property (osc_idle_s |-> !$rose(osc_out))
    else $error("oscillator pulse while idle");
  AST_WERR_DEADLINE: assert property ($rose(write_error) |-> stb_age_r <= 20'hfa8)
    else $error("write error raised late");
  AST_WERR_HOLD: assert property ($fell(write_error) |-> write_strobe)
    else $error("write error dropped without strobe");
  AST_STROBE_GATED: assert property ($rose(write_strobe) |-> $past(ready && !gap_active))
    else $error("strobe while not ready or in gap");
endmodule
`default_nettype wire

// ==== dv/tb_tape_writer_host_status_port.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_tape_writer_host_status_port;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        data_clk;
  logic [4:0]  pin;
  logic        motor_step;
  logic        motor_fwd;
  logic [6:0]  head_data;
  logic        head_write;
  logic [31:0] rd;
  logic        err;
  logic        osc_d;
  logic [6:0]  hw_data;
  logic        hw_fwd;
  logic        hw_step;
  logic [5:0]  chars [4] = '{6'h2a, 6'h15, 6'h3f, 6'h01};
  int          hw_n;
  int          n_osc;
  int          n_dclk;
  int          n;
  int          m;
  int          n_mismatch;
  int          check_count;
  tape_link_if link ();
  tape_controller u_tape_controller (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq, .data_clk, .link(link));
  tape_device #(.OSC_NOM_CYC(20'h195), .OSC_START_CYC(20'h1e0), .SETTLE_CYC(20'hc8))
    u_tape_device (.pclk, .presetn, .link(link), .load_req_pin(pin[0]),
    .load_point_pin(pin[1]), .end_marker_pin(pin[2]), .head_current_pin(pin[3]),
    .echo_fail_pin(pin[4]), .motor_step, .motor_fwd, .head_data, .head_write);
  tape_link_asserts #(.SETTLE_CYC(200)) u_tape_link_asserts (.pclk, .presetn,
    .slew(link.slew), .write_strobe(link.write_strobe), .eor_cmd(link.eor_cmd),
    .eof_cmd(link.eof_cmd), .ready(link.ready), .gap_active(link.gap_active),
    .write_error(link.write_error), .osc_out(link.osc_out));
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ----------------------------------------
  // Monitors and tasks
  // ----------------------------------------
  always @(posedge pclk)
  begin
    osc_d <= link.osc_out;
    if (link.osc_out === 1'b1 && osc_d === 1'b0)
      n_osc <= n_osc + 1;
    if (data_clk === 1'b1)
      n_dclk <= n_dclk + 1;
    if (head_write === 1'b1)
    begin
      hw_n <= hw_n + 1;
      hw_data <= head_data;
      hw_fwd <= motor_fwd;
      hw_step <= motor_step;
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      k++;
      if (k > 16)
      begin
        n_mismatch++;
        give_verdict();
      end
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_stat(input logic [31:0] msk, input logic [31:0] v, input int lim);
    int k;
    k = 0;
    do
    begin
      apb(1'b0, 12'h00c, 32'h0);
      k++;
    end
    while ((rd & msk) !== v && k < lim);
    chk("stat wait", v, rd & msk);
    if ((rd & msk) !== v)
      give_verdict();
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pin = 5'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl", 32'h3, rd);
    apb(1'b0, 12'h00c, 32'h0);
    chk("stat", 32'h0, rd);
    apb(1'b0, 12'h020, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'b1, 12'h014, 32'h8);
    apb(1'b1, 12'h004, 32'h15);
    chk("irq refused", 32'h1, {31'h0, irq});
    chk("no char", 32'h0, hw_n);
    apb(1'b1, 12'h010, 32'h8);
    chk("irq clear", 32'h0, {31'h0, irq});
    $display("test reset done");
    pin <= 5'h09;
    repeat (200) @(posedge pclk);
    pin <= 5'h0a;
    wait_stat(32'ha, 32'ha, 100);
    pin <= 5'h08;
    wait_stat(32'h3, 32'h1, 30000);
    $display("test load done");
    for (int i = 0; i < 4; i++)
    begin
      n = hw_n;
      apb(1'b1, 12'h000, i);
      apb(1'b1, 12'h004, {26'h0, chars[i]});
      wait_stat(32'h20, 32'h0, 400);
      chk("char count", n + 1, hw_n);
      chk("head data", {25'h0, ^chars[i] ^ ~i[1], chars[i]}, {25'h0, hw_data});
      chk("direction", {31'h0, i[0]}, {31'h0, hw_fwd});
      chk("step", 32'h1, {31'h0, hw_step});
    end
    apb(1'b1, 12'h000, 32'h3);
    $display("test write done");
    pin <= 5'h18;
    apb(1'b1, 12'h014, 32'h1);
    apb(1'b1, 12'h004, 32'h2a);
    wait_stat(32'h10, 32'h10, 1500);
    pin <= 5'h08;
    wait_stat(32'h20, 32'h0, 400);
    apb(1'b0, 12'h00c, 32'h0);
    chk("werr held", 32'h10, rd & 32'h10);
    chk("irq werr", 32'h1, {31'h0, irq});
    apb(1'b1, 12'h004, 32'h2a);
    wait_stat(32'h10, 32'h0, 20);
    apb(1'b1, 12'h010, 32'hf);
    $display("test echo done");
    pin <= 5'h0c;
    wait_stat(32'h4, 32'h4, 20);
    apb(1'b0, 12'h010, 32'h0);
    chk("irq end", 32'h4, rd & 32'h4);
    pin <= 5'h08;
    wait_stat(32'h4, 32'h0, 20);
    $display("test end marker done");
    n = n_osc;
    m = n_dclk;
    apb(1'b1, 12'h000, 32'h7);
    repeat (3000) @(posedge pclk);
    apb(1'b1, 12'h000, 32'h3);
    chk("slew osc", 32'h1, {31'h0, n_osc - n > 3});
    chk("data clk", 32'h1, {31'h0, n_dclk - m > 3});
    $display("test slew done");
    apb(1'b1, 12'h014, 32'h2);
    repeat (1000) @(posedge pclk);
    n = n_osc;
    m = n_dclk;
    apb(1'b1, 12'h008, 32'h1);
    wait_stat(32'h2, 32'h2, 10);
    apb(1'b1, 12'h004, 32'h3f);
    apb(1'b1, 12'h008, 32'h2);
    apb(1'b0, 12'h010, 32'h0);
    chk("refused", 32'h8, rd & 32'h8);
    wait_stat(32'h2, 32'h0, 25000);
    chk("gap osc", 32'h1, {31'h0, n_osc - n >= 150});
    chk("gap dclk", m, n_dclk);
    chk("irq gap", 32'h1, {31'h0, irq});
    $display("test gap done");
    give_verdict();
  end
endmodule
`default_nettype wire
